/* rtl/gtm_timer.sv */
`timescale 1ns/1ps
// Behaviour
// - 16-bit interval timer or event counter
// - count reset only by power-up reset, not by reset
// - timer, synchronous and asynchronous counter modes
// - keeps counting in sleep only in asynchronous counter mode
// - irq on period match outside gated mode, or on gate fall in gated mode
// - counting only while timer_run_enable set
// - prescale_select picks clock division ratio
// - clock source and gate enable select inputs
// - external_sync_select chooses synchronised external clock
module gtm_timer #(
	parameter int ADDR_W = 5,
	parameter int CNT_W  = 16
) (
	input  wire logic              core_clk,
	input  wire logic              reset,
	input  wire logic              powerOnReset,
	input  wire logic              extClk,
	input  wire logic              gateIn,
	input  wire logic              cpuSleep,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic [2:0]        s_axi_awprot,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic [2:0]        s_axi_arprot,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	output logic                   irqOut,
	output logic [2:0]             irqPriority
);

	// byte-lane merge of a 16-bit register with write data
	function automatic logic [15:0] mergeLanes(input logic [15:0] old,
	                                           input logic [31:0] data,
	                                           input logic [3:0]  strb);
		logic [15:0] res;
		res = old;
		if (strb[0]) begin
			res[7:0] = data[7:0];
		end
		if (strb[1]) begin
			res[15:8] = data[15:8];
		end
		return res;
	endfunction : mergeLanes

	// one-hot register select for a bus address, all zero when unmapped
	function automatic logic [4:0] regSelect(input logic [ADDR_W-1:0] addr);
		logic [4:0] sel;
		sel    = 5'h00;
		sel[0] = addr == ADDR_W'(gtm_pkg::CTRL_OFS);
		sel[1] = addr == ADDR_W'(gtm_pkg::COUNT_OFS);
		sel[2] = addr == ADDR_W'(gtm_pkg::PERIOD_OFS);
		sel[3] = addr == ADDR_W'(gtm_pkg::STATUS_OFS);
		sel[4] = addr == ADDR_W'(gtm_pkg::MASK_OFS);
		return sel;
	endfunction : regSelect

	// register state
	logic [15:0]                  ctrl_ff;
	logic [CNT_W-1:0]             count_ff;
	logic [CNT_W-1:0]             period_ff;
	logic [gtm_pkg::ST_W-1:0]     status_ff;
	logic [gtm_pkg::ST_W-1:0]     mask_ff;
	logic                         irq_ff;
	logic [15:0]                  nxt_ctrl;
	logic [CNT_W-1:0]             nxt_count;
	logic [CNT_W-1:0]             nxt_period;
	logic [gtm_pkg::ST_W-1:0]     nxt_status;
	logic [gtm_pkg::ST_W-1:0]     nxt_mask;

	// bus state
	logic              awHeld_ff;
	logic              wHeld_ff;
	logic [ADDR_W-1:0] awAddr_ff;
	logic [31:0]       wData_ff;
	logic [3:0]        wStrb_ff;
	logic [1:0]        bresp_ff;
	logic              bvalid_ff;
	logic [31:0]       rdata_ff;
	logic [1:0]        rresp_ff;
	logic              rvalid_ff;

	// input edge tracking
	logic extSync1_ff;
	logic extSync2_ff;
	logic extSyncPrev_ff;
	logic extRawPrev_ff;
	logic gatePrev_ff;

	// write channel decode
	wire              awTake   = s_axi_awvalid & s_axi_awready;
	wire              wTake    = s_axi_wvalid & s_axi_wready;
	wire              haveAw   = awHeld_ff | awTake;
	wire              haveW    = wHeld_ff | wTake;
	wire              wrDo     = haveAw & haveW & ~bvalid_ff;
	wire [ADDR_W-1:0] wrAddr   = awHeld_ff ? awAddr_ff : s_axi_awaddr;
	wire [31:0]       wrData   = wHeld_ff ? wData_ff : s_axi_wdata;
	wire [3:0]        wrStrb   = wHeld_ff ? wStrb_ff : s_axi_wstrb;
	wire [4:0]        wrSel    = regSelect(wrAddr) & {5{wrDo}};
	wire              wrCtrl   = wrSel[0];
	wire              wrCount  = wrSel[1];
	wire              wrPeriod = wrSel[2];
	wire              wrStatus = wrSel[3];
	wire              wrMask   = wrSel[4];
	wire              wrHit    = |wrSel;

	// read channel decode
	wire        rdDo    = s_axi_arvalid & s_axi_arready;
	wire [4:0]  rdSel   = regSelect(s_axi_araddr);
	wire        rdCtrl  = rdSel[0];
	wire        rdCount = rdSel[1];
	wire        rdPer   = rdSel[2];
	wire        rdStat  = rdSel[3];
	wire        rdMask  = rdSel[4];
	wire        rdHit   = |rdSel;
	wire [31:0] rdMux   = rdCtrl  ? {16'h0000, ctrl_ff} :
	                      rdCount ? {16'h0000, count_ff} :
	                      rdPer   ? {16'h0000, period_ff} :
	                      rdStat  ? {30'h00000000, status_ff} :
	                      rdMask  ? {30'h00000000, mask_ff} : 32'h00000000;

	// handshake outputs
	assign s_axi_awready = ~awHeld_ff & ~bvalid_ff;
	assign s_axi_wready  = ~wHeld_ff & ~bvalid_ff;
	assign s_axi_arready = ~rvalid_ff;
	assign s_axi_bresp   = bresp_ff;
	assign s_axi_bvalid  = bvalid_ff;
	assign s_axi_rdata   = rdata_ff;
	assign s_axi_rresp   = rresp_ff;
	assign s_axi_rvalid  = rvalid_ff;

	// control fields
	wire       runEn    = ctrl_ff[gtm_pkg::CTRL_RUN_BIT];
	wire [1:0] pscSel   = ctrl_ff[gtm_pkg::CTRL_PSC_LSB +: 2];
	wire       srcExt   = ctrl_ff[gtm_pkg::CTRL_SRC_BIT];
	wire       gateEn   = ctrl_ff[gtm_pkg::CTRL_GATE_BIT];
	wire       syncSel  = ctrl_ff[gtm_pkg::CTRL_SYNC_BIT];
	assign irqPriority  = ctrl_ff[gtm_pkg::CTRL_PRIO_LSB +: 3];

	// source tick selection
	wire syncRise  = extSync2_ff & ~extSyncPrev_ff;
	wire asyncRise = extClk & ~extRawPrev_ff;
	wire extTick   = syncSel ? syncRise : asyncRise;
	wire srcTick   = srcExt ? extTick : 1'b1;

	// run, gate and sleep qualification of the source tick
	wire asyncMode = srcExt & ~syncSel;
	wire sysHalt   = cpuSleep & ~asyncMode;
	wire gatedMode = gateEn & ~srcExt;
	wire gateOk    = ~gatedMode | gateIn;
	wire preIn     = runEn & srcTick & gateOk & ~sysHalt;

	logic incTick;

	// prescaler restarts when stopped or when the count is loaded
	gtm_prescaler #(
		.CNT_W(8)
	) gtm_prescaler_i (
		.core_clk   (core_clk),
		.reset      (reset),
		.clear      (~runEn | wrCount),
		.tickIn     (preIn),
		.prescaleSel(pscSel),
		.tickOut    (incTick)
	);

	// period match and gate falling edge events
	wire periodHit = incTick & (count_ff == period_ff);
	wire gateFall  = runEn & gatedMode & gatePrev_ff & ~gateIn;
	wire [gtm_pkg::ST_W-1:0] evSet = {gateFall, periodHit & ~gatedMode};
	wire [gtm_pkg::ST_W-1:0] evClr = wrStatus & wrStrb[0] ?
	                                 wrData[gtm_pkg::ST_W-1:0] : '0;

	// next register values
	assign nxt_ctrl   = wrCtrl ? mergeLanes(ctrl_ff, wrData, wrStrb) : ctrl_ff;
	assign nxt_period = wrPeriod ? mergeLanes(period_ff, wrData, wrStrb) : period_ff;
	assign nxt_mask   = wrMask & wrStrb[0] ? wrData[gtm_pkg::ST_W-1:0] : mask_ff;
	assign nxt_status = (status_ff & ~evClr) | evSet; // set wins over clear
	assign nxt_count  = wrCount   ? mergeLanes(count_ff, wrData, wrStrb) :
	                    periodHit ? '0 :
	                    incTick   ? count_ff + CNT_W'(1) : count_ff;

	// count survives every reset except power-up
	always_ff @(posedge core_clk or posedge powerOnReset) begin
		if (powerOnReset) begin
			count_ff <= gtm_pkg::COUNT_RST;
		end else begin
			count_ff <= nxt_count;
		end
	end

	// software visible control, period, status and mask
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			ctrl_ff   <= gtm_pkg::CTRL_RST;
			period_ff <= gtm_pkg::PERIOD_RST;
			status_ff <= gtm_pkg::STATUS_RST;
			mask_ff   <= gtm_pkg::MASK_RST;
		end else begin
			ctrl_ff   <= nxt_ctrl;
			period_ff <= nxt_period;
			status_ff <= nxt_status;
			mask_ff   <= nxt_mask;
		end
	end

	// level interrupt, high while an enabled event is pending
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= |(nxt_status & nxt_mask);
		end
	end
	assign irqOut = irq_ff;

	// two-flop synchroniser for the external clock
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			extSync1_ff <= 1'b0;
			extSync2_ff <= 1'b0;
		end else begin
			extSync1_ff <= extClk;
			extSync2_ff <= extSync1_ff;
		end
	end

	// previous levels for edge detection, idle low like the pins
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			extSyncPrev_ff <= 1'b0;
			extRawPrev_ff  <= 1'b0;
			gatePrev_ff    <= 1'b0;
		end else begin
			extSyncPrev_ff <= extSync2_ff;
			extRawPrev_ff  <= extClk;
			gatePrev_ff    <= gateIn;
		end
	end

	// write address and data capture
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			awHeld_ff <= 1'b0;
			wHeld_ff  <= 1'b0;
			awAddr_ff <= '0;
			wData_ff  <= 32'h00000000;
			wStrb_ff  <= 4'h0;
		end else begin
			awHeld_ff <= haveAw & ~wrDo;
			wHeld_ff  <= haveW & ~wrDo;
			if (awTake) begin
				awAddr_ff <= s_axi_awaddr;
			end
			if (wTake) begin
				wData_ff <= s_axi_wdata;
				wStrb_ff <= s_axi_wstrb;
			end
		end
	end

	// write response, held until bready
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			bvalid_ff <= 1'b0;
			bresp_ff  <= gtm_pkg::RESP_OKAY;
		end else if (wrDo) begin
			bvalid_ff <= 1'b1;
			bresp_ff  <= wrHit ? gtm_pkg::RESP_OKAY : gtm_pkg::RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_ff <= 1'b0;
		end
	end

	// read data and response, held until rready
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			rvalid_ff <= 1'b0;
			rdata_ff  <= 32'h00000000;
			rresp_ff  <= gtm_pkg::RESP_OKAY;
		end else if (rdDo) begin
			rvalid_ff <= 1'b1;
			rdata_ff  <= rdMux;
			rresp_ff  <= rdHit ? gtm_pkg::RESP_OKAY : gtm_pkg::RESP_SLVERR;
		end else if (s_axi_rready) begin
			rvalid_ff <= 1'b0;
		end
	end

endmodule : gtm_timer

/* common/gtm_pkg.sv */
package gtm_pkg;

	// register byte offsets
	localparam logic [4:0] CTRL_OFS   = 5'h00;
	localparam logic [4:0] COUNT_OFS  = 5'h04;
	localparam logic [4:0] PERIOD_OFS = 5'h08;
	localparam logic [4:0] STATUS_OFS = 5'h0C;
	localparam logic [4:0] MASK_OFS   = 5'h10;

	// control register field positions
	localparam int CTRL_RUN_BIT   = 15;
	localparam int CTRL_PRIO_LSB  = 8;
	localparam int CTRL_GATE_BIT  = 6;
	localparam int CTRL_PSC_LSB   = 4;
	localparam int CTRL_SYNC_BIT  = 2;
	localparam int CTRL_SRC_BIT   = 1;

	// status and mask bit positions
	localparam int ST_MATCH_BIT = 0;
	localparam int ST_GATE_BIT  = 1;
	localparam int ST_W         = 2;

	// values after reset
	localparam logic [15:0]     CTRL_RST   = 16'h0400;
	localparam logic [15:0]     COUNT_RST  = 16'h0000;
	localparam logic [15:0]     PERIOD_RST = 16'hFFFF;
	localparam logic [ST_W-1:0] STATUS_RST = 2'h0;
	localparam logic [ST_W-1:0] MASK_RST   = 2'h0;

	// prescale ratios for each code of prescale_select
	localparam logic [7:0] PSC_DIV0 = 8'h01;
	localparam logic [7:0] PSC_DIV1 = 8'h02;
	localparam logic [7:0] PSC_DIV2 = 8'h04;
	localparam logic [7:0] PSC_DIV3 = 8'h08;

	// bus responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : gtm_pkg

/* rtl/gtm_prescaler.sv */
`timescale 1ns/1ps
// divides qualified source ticks by the ratio chosen with prescale_select
module gtm_prescaler #(
	parameter int CNT_W = 8
) (
	input  wire logic       core_clk,
	input  wire logic       reset,
	input  wire logic       clear,
	input  wire logic       tickIn,
	input  wire logic [1:0] prescaleSel,
	output logic            tickOut
);

	logic [CNT_W-1:0] cnt_ff;
	logic [CNT_W-1:0] nxt_cnt;
	logic [CNT_W-1:0] lastCnt;
	logic             wrapNow;

	// ratio minus one is the last count before an output tick
	assign lastCnt = (prescaleSel == 2'h0) ? CNT_W'(gtm_pkg::PSC_DIV0 - 8'h01) :
	                 (prescaleSel == 2'h1) ? CNT_W'(gtm_pkg::PSC_DIV1 - 8'h01) :
	                 (prescaleSel == 2'h2) ? CNT_W'(gtm_pkg::PSC_DIV2 - 8'h01) :
	                                         CNT_W'(gtm_pkg::PSC_DIV3 - 8'h01);
	assign wrapNow = tickIn & (cnt_ff >= lastCnt);
	assign tickOut = wrapNow & ~clear;
	assign nxt_cnt = clear   ? '0 :
	                 wrapNow ? '0 :
	                 tickIn  ? cnt_ff + CNT_W'(1) : cnt_ff;

	// division counter
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			cnt_ff <= '0;
		end else begin
			cnt_ff <= nxt_cnt;
		end
	end

endmodule : gtm_prescaler

/* tb/gtm_timer_properties.sv */
`timescale 1ns/1ps
// bus timing and interrupt output checks at the timer ports
module gtm_timer_properties #(
	parameter int ADDR_W = 5
) (
	input wire logic              core_clk,
	input wire logic              reset,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic              s_axi_awvalid,
	input wire logic              s_axi_awready,
	input wire logic [31:0]       s_axi_wdata,
	input wire logic [3:0]        s_axi_wstrb,
	input wire logic              s_axi_wvalid,
	input wire logic              s_axi_wready,
	input wire logic              s_axi_bvalid,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic              s_axi_arvalid,
	input wire logic              s_axi_arready,
	input wire logic [31:0]       s_axi_rdata,
	input wire logic [1:0]        s_axi_rresp,
	input wire logic              s_axi_rvalid,
	input wire logic              irqOut,
	input wire logic [2:0]        irqPriority
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);
	logic [2:0] prioW_ff;
	// transfers taken at this edge
	wire wrBoth = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	wire arTake = s_axi_arvalid && s_axi_arready;
	wire wrCtrl = wrBoth && s_axi_awaddr == gtm_pkg::CTRL_OFS && s_axi_wstrb[1];
	wire wrMask0 = wrBoth && s_axi_awaddr == gtm_pkg::MASK_OFS && s_axi_wdata[1:0] == 2'h0;
	// last priority offered on the write data channel
	always_ff @(posedge core_clk) if (s_axi_wvalid) prioW_ff <= s_axi_wdata[10:8];
	AST_BRESP_TIME: assert property (wrBoth |=> s_axi_bvalid)
		else $error("write response late");
	AST_BUSY_AW: assert property (s_axi_bvalid |-> !s_axi_awready)
		else $error("address taken during response");
	AST_RDATA_TIME: assert property (arTake |=> s_axi_rvalid)
		else $error("read data late");
	AST_BUSY_AR: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address taken during data");
	AST_UNMAPPED: assert property (arTake && s_axi_araddr > gtm_pkg::MASK_OFS
		|=> s_axi_rresp == gtm_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
		else $error("unmapped read not refused");
	AST_STATUS_RD: assert property (arTake && s_axi_araddr == gtm_pkg::STATUS_OFS
		|=> s_axi_rresp == gtm_pkg::RESP_OKAY && s_axi_rdata[31:2] == 30'h0)
		else $error("status read malformed");
	AST_MASK_OFF: assert property (wrMask0 |=> ##1 !irqOut)
		else $error("interrupt with all events masked");
	AST_PRIO: assert property (wrCtrl |=> ##1 irqPriority == prioW_ff)
		else $error("priority output not following control");
	AST_RST_IDLE: assert property (disable iff (1'b0)
		reset |-> !irqOut && !s_axi_bvalid && !s_axi_rvalid)
		else $error("outputs active in reset");
endmodule : gtm_timer_properties

bind gtm_timer gtm_timer_properties #(.ADDR_W(ADDR_W)) gtm_timer_properties_i (.core_clk,
	.reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .irqOut, .irqPriority);

/* tb/gtm_ext_src.sv */
`timescale 1ns/1ps
// external clock and gate source, still between bursts
module gtm_ext_src (
	input wire logic core_clk,
	output logic     extClk,
	output logic     gateIn
);
	initial begin
		extClk = 1'b0;
		gateIn = 1'b0;
	end
	// rising edges spaced wide enough for the synchroniser
	task automatic pulses(input int n);
		repeat (n) begin
			@(posedge core_clk) extClk <= 1'b1;
			repeat (2) @(posedge core_clk);
			extClk <= 1'b0;
			repeat (3) @(posedge core_clk);
		end
	endtask : pulses
	// gate held open for n cycles then dropped
	task automatic gate(input int n);
		@(posedge core_clk) gateIn <= 1'b1;
		repeat (n) @(posedge core_clk);
		gateIn <= 1'b0;
	endtask : gate
endmodule : gtm_ext_src

/* tb/tb_gtm_timer.sv */
`timescale 1ns/1ps
// timer tests as sequences of register accesses
module tb_gtm_timer;
	logic        core_clk = 1'b0;
	logic        reset = 1'b0;
	logic        powerOnReset = 1'b0;
	logic        cpuSleep = 1'b0;
	logic        extClk, gateIn;
	logic [4:0]  s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
	logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdData;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rdResp, wrResp;
	logic        irqOut;
	logic [2:0]  irqPriority;
	int          fail_count = 0, comparisons = 0;
	logic [15:0] ctrlTab [7] = '{16'h8006, 16'h8016, 16'h8026, 16'h8036, 16'h0006, 16'h8002,
		16'h8006};
	logic        sleepTab [7] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
	logic [31:0] expTab [7] = '{32'h00000010, 32'h00000008, 32'h00000004, 32'h00000002,
		32'h00000000, 32'h00000010, 32'h00000000};

	always #12.5 core_clk = ~core_clk;

	gtm_ext_src gtm_ext_src_i (.core_clk, .extClk, .gateIn);
	gtm_timer gtm_timer_i (.core_clk, .reset, .powerOnReset, .extClk, .gateIn, .cpuSleep,
		.s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irqOut, .irqPriority);

	// verdict and end of run
	task automatic tally_and_finish();
		$display("comparisons %0d fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : tally_and_finish
	// a wait that ran out
	task automatic hang(input string what);
		fail_count++;
		$display("Error %s expected answer seen none", what);
		tally_and_finish();
	endtask : hang
	task automatic chkWord(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : chkWord
	task automatic chkFlag(input string what, input logic exp, input logic got);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("Error %s expected %b seen %b", what, exp, got);
		end
	endtask : chkFlag
	// one write, both channels offered together
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge core_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (++n > 40) hang("write");
		end while (!s_axi_bvalid);
		wrResp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : wr
	// one read, data and response kept
	task automatic rd(input logic [4:0] a);
		int n;
		n = 0;
		@(posedge core_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge core_clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (++n > 40) hang("read");
		end while (!s_axi_rvalid);
		rdData = s_axi_rdata;
		rdResp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : rd
	task automatic rdChk(input logic [4:0] a, input logic [31:0] exp, input string what);
		rd(a);
		chkWord(what, exp, rdData);
	endtask : rdChk

	// main sequence
	initial begin
		// raised by a nonblocking assignment at time zero so that the asynchronous resets see an edge
		reset <= 1'b1;
		powerOnReset <= 1'b1;
		repeat (16) @(posedge core_clk);
		reset <= 1'b0;
		powerOnReset <= 1'b0;
		rdChk(gtm_pkg::CTRL_OFS, 32'(gtm_pkg::CTRL_RST), "ctrl reset");
		rdChk(gtm_pkg::COUNT_OFS, 32'h0, "count power-up");
		rdChk(gtm_pkg::PERIOD_OFS, 32'(gtm_pkg::PERIOD_RST), "period reset");
		rdChk(gtm_pkg::STATUS_OFS, 32'h0, "status reset");
		rdChk(gtm_pkg::MASK_OFS, 32'h0, "mask reset");
		rd(5'h14);
		chkWord("unmapped resp", 32'(gtm_pkg::RESP_SLVERR), 32'(rdResp));
		wr(5'h14, 32'h0000FFFF);
		chkWord("unmapped write resp", 32'(gtm_pkg::RESP_SLVERR), 32'(wrResp));
		chkWord("prio reset", 32'(gtm_pkg::CTRL_RST[10:8]), 32'(irqPriority));
		// sync, prescale, run and sleep combinations on the external source
		for (int i = 0; i < 7; i++) begin
			wr(gtm_pkg::CTRL_OFS, 32'h0);
			wr(gtm_pkg::COUNT_OFS, 32'h0);
			cpuSleep <= sleepTab[i];
			wr(gtm_pkg::CTRL_OFS, 32'(ctrlTab[i]));
			gtm_ext_src_i.pulses(16);
			repeat (5) @(posedge core_clk);
			rdChk(gtm_pkg::COUNT_OFS, expTab[i], "count mode");
		end
		cpuSleep <= 1'b0;
		// period match, wrap and interrupt
		wr(gtm_pkg::CTRL_OFS, 32'h0);
		wr(gtm_pkg::PERIOD_OFS, 32'h3);
		chkWord("period write resp", 32'(gtm_pkg::RESP_OKAY), 32'(wrResp));
		wr(gtm_pkg::COUNT_OFS, 32'h0);
		wr(gtm_pkg::MASK_OFS, 32'h1);
		wr(gtm_pkg::CTRL_OFS, 32'h8506);
		chkWord("priority", 32'h00000005, 32'(irqPriority));
		gtm_ext_src_i.pulses(4);
		repeat (5) @(posedge core_clk);
		rdChk(gtm_pkg::COUNT_OFS, 32'h0, "count wrap");
		rdChk(gtm_pkg::STATUS_OFS, 32'h1, "match flag");
		chkFlag("match irq", 1'b1, irqOut);
		gtm_ext_src_i.pulses(1);
		repeat (5) @(posedge core_clk);
		rdChk(gtm_pkg::COUNT_OFS, 32'h1, "count after wrap");
		wr(gtm_pkg::MASK_OFS, 32'h0);
		repeat (2) @(posedge core_clk);
		chkFlag("masked irq", 1'b0, irqOut);
		wr(gtm_pkg::STATUS_OFS, 32'h1);
		rdChk(gtm_pkg::STATUS_OFS, 32'h0, "flag cleared");
		// device reset alone keeps the count
		reset <= 1'b1;
		repeat (2) @(posedge core_clk);
		reset <= 1'b0;
		rdChk(gtm_pkg::COUNT_OFS, 32'h1, "count kept");
		rdChk(gtm_pkg::CTRL_OFS, 32'(gtm_pkg::CTRL_RST), "ctrl after reset");
		// gated counting on the internal clock
		wr(gtm_pkg::COUNT_OFS, 32'h0);
		wr(gtm_pkg::MASK_OFS, 32'h2);
		wr(gtm_pkg::CTRL_OFS, 32'h8040);
		rdChk(gtm_pkg::COUNT_OFS, 32'h0, "gate closed");
		gtm_ext_src_i.gate(10);
		repeat (3) @(posedge core_clk);
		rdChk(gtm_pkg::COUNT_OFS, 32'h0000000A, "gated count");
		rdChk(gtm_pkg::STATUS_OFS, 32'h2, "gate flag");
		chkFlag("gate irq", 1'b1, irqOut);
		tally_and_finish();
	end
endmodule : tb_gtm_timer
